// *** rtl/lcdbs_bus_slave.sv ***
// two-wire write-only slave of the segment display driver
// assumes open-drain pads resolved outside, row strobe from the
// display timing, and slow pins synchronised here
//
// Overview of operation
// - four-way mux shows bits 0,1,2,3 in turn
// - three-way mux shows bits 0,1,2 in turn
// - two-way shows bits 0,1; static bit 0
// - static alternate output bank shows bit 2
// - two-way alternate output bank shows bits 2,3
// - alternate input bank writes bits 2(,3)
// - input and output bank held separately
// - normal mode blink divisors 92160/184320/368640 or off
// - power-saving blink divisors 15360/30720/61440
// - alternation blinking swaps banks at blink rate
// - display blanked while enable bit cleared
// - start and stop detected while clock high
// - receive only, drive only acknowledge bits and clock stretch
// - acknowledge holds data low through ninth pulse
// - clock held low until byte stored
// - answer address 011111x, lsb from pin
// - address mismatch ignores transfer until start
// - cleared top bit marks last command
// - address and commands acknowledged always when addressed
// - data stored at pointer, pointer advances
// - data acknowledged only on subaddress match
// - after last command all bytes are data
// - pointer advances 8/4/3/2 per byte
// - write only on match, overflow bumps subaddress
// - bank select and alternation ignored in 3/4-way
`default_nettype none
module lcdbs_bus_slave
  import lcdbs_pkg::*;
#(
  parameter int BLINK_N2 = DIV_N_2HZ,
  parameter int BLINK_N1 = DIV_N_1HZ,
  parameter int BLINK_N05 = DIV_N_05HZ,
  parameter int BLINK_P2 = DIV_P_2HZ,
  parameter int BLINK_P1 = DIV_P_1HZ,
  parameter int BLINK_P05 = DIV_P_05HZ
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic address_lsb_select_pin,
  input wire logic hw_subaddr_bit0,
  input wire logic hw_subaddr_bit1,
  input wire logic hw_subaddr_bit2,
  input wire logic rowAdvance,
  output logic [RAM_DEPTH-1:0] segLatch,
  output logic [1:0] rowIdx,
  output lcdbs_mode_type modeCfg,
  output logic displayOn
);
  // ********************************************************
  // declarations
  // ********************************************************
  typedef enum logic [1:0] {BS_IDLE, BS_SHIFT, BS_ACK, BS_IGNORE} lcdbs_bus_type;
  typedef enum logic [1:0] {KIND_ADDR, KIND_CMD, KIND_DATA} lcdbs_kind_type;

  localparam int SYNC_W = 6; // scl, sda, lsb pin, three subaddress pins

  logic [SYNC_W-1:0] syncMeta; // first stage, read by second only
  logic [SYNC_W-1:0] syncPin; // second stage, safe to use
  logic sclD; // previous synced clock
  logic sdaD; // previous synced data
  logic sclS; // synced clock
  logic sdaS; // synced data
  logic lsbS; // synced address lsb
  logic [2:0] hwSub; // synced hardware subaddress
  logic startEv; // start seen
  logic stopEv; // stop seen
  logic sclRise; // clock rising
  logic sclFall; // clock falling
  lcdbs_bus_type busState; // bit level state
  lcdbs_kind_type kind; // meaning of the byte in flight
  logic [3:0] bitCnt; // bits taken of current byte
  logic [BYTE_BITS-1:0] shiftReg; // incoming byte
  logic byteDone; // eight bits in, clock fell
  logic addrHit; // address matches this device
  logic ackNow; // acknowledge the finished byte
  logic cmdStrobe; // a command byte completed
  logic dataStrobe; // a data byte completed
  lcdbs_blink_type blinkCfg; // blink command state
  logic inBank; // input bank choice
  logic outBank; // output bank choice
  logic [4:0] dataPtr; // ram address of next write
  logic [2:0] subCnt; // subaddress counter
  logic storeBusy; // byte being scattered into ram
  logic [BYTE_BITS-1:0] storeShift; // bits still to place
  logic [3:0] storeLeft; // count of bits still to place
  logic [2:0] width; // ram bits per address
  logic [1:0] inBase; // first ram bit written
  logic [1:0] outBase; // first ram bit shown
  logic [3:0] take; // bits placed this cycle
  logic ramWe; // ram write enable
  logic [RAM_BITS-1:0] ramMask; // ram bits touched
  logic [RAM_BITS-1:0] ramData; // ram bits written
  logic [RAM_DEPTH-1:0] column; // selected ram column
  logic blinkPhase; // blink half period
  logic swapBank; // alternation swap active
  logic blankNow; // blinking blank half
  logic [2:0] rowsLast; // last row of current mode

  // ********************************************************
  // pin synchronisers and bus conditions
  // ********************************************************
  // two flops on every pin before any logic reads it
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      syncMeta <= {SYNC_RST, 3'h0};
      syncPin <= {SYNC_RST, 3'h0};
    end
    else
    begin
      syncMeta <= {sclIn, sdaIn, address_lsb_select_pin, hw_subaddr_bit2, hw_subaddr_bit1, hw_subaddr_bit0};
      syncPin <= syncMeta;
    end
  end

  // previous values for edge detection
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end
    else
    begin
      sclD <= sclS;
      sdaD <= sdaS;
    end
  end

  assign sclS = syncPin[5];
  assign sdaS = syncPin[4];
  assign lsbS = syncPin[3];
  assign hwSub = syncPin[2:0];
  // data edges with clock steady high are control conditions
  assign startEv = sclS && sclD && sdaD && !sdaS;
  assign stopEv = sclS && sclD && !sdaD && sdaS;
  assign sclRise = sclS && !sclD;
  assign sclFall = !sclS && sclD;

  // ********************************************************
  // byte reception and acknowledge
  // ********************************************************
  assign byteDone = (busState == BS_SHIFT) && sclFall && (bitCnt == 4'(BYTE_BITS));
  // write direction only; a read request is left alone
  assign addrHit = (shiftReg[7:1] == {ADDR_UPPER, lsbS}) && !shiftReg[0];

  // which finished byte gets an acknowledge
  always_comb
  begin
    case (kind)
      KIND_ADDR: ackNow = addrHit;
      KIND_CMD: ackNow = 1'b1;
      KIND_DATA: ackNow = (subCnt == hwSub);
      default: ackNow = 1'b0;
    endcase
  end

  assign cmdStrobe = byteDone && (kind == KIND_CMD);
  assign dataStrobe = byteDone && (kind == KIND_DATA);

  // bit level sequencing, acknowledge drive is its only output
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busState <= BS_IDLE;
      kind <= KIND_ADDR;
      bitCnt <= '0;
      shiftReg <= '0;
      sdaOe <= 1'b0;
    end
    else if (startEv)
    begin
      // partial byte dropped, new address expected
      busState <= BS_SHIFT;
      kind <= KIND_ADDR;
      bitCnt <= '0;
      sdaOe <= 1'b0;
    end
    else if (stopEv)
    begin
      busState <= BS_IDLE;
      kind <= KIND_ADDR;
      bitCnt <= '0;
      sdaOe <= 1'b0;
    end
    else
    begin
      case (busState)
        BS_SHIFT:
        begin
          // sample on rising clock, msb first
          if (sclRise && (bitCnt < 4'(BYTE_BITS)))
          begin
            shiftReg <= {shiftReg[BYTE_BITS-2:0], sdaS};
            bitCnt <= bitCnt + 1'b1;
          end
          if (byteDone)
          begin
            bitCnt <= '0;
            if ((kind == KIND_ADDR) && !addrHit)
            begin
              busState <= BS_IGNORE;
            end
            else
            begin
              busState <= BS_ACK;
              sdaOe <= ackNow;
            end
            // next byte meaning
            if (kind == KIND_ADDR)
            begin
              kind <= KIND_CMD;
            end
            else if ((kind == KIND_CMD) && !shiftReg[CONT_BIT])
            begin
              kind <= KIND_DATA;
            end
          end
        end
        BS_ACK:
        begin
          // release after the falling edge of the ninth pulse
          if (sclFall)
          begin
            sdaOe <= 1'b0;
            busState <= BS_SHIFT;
          end
        end
        BS_IGNORE:
        begin
          sdaOe <= 1'b0;
        end
        default:
        begin
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

  // open-drain: only ever pull low
  assign sdaOut = 1'b0;
  assign sclOut = 1'b0;
  // clock stretched while the ram scatter runs
  assign sclOe = storeBusy;

  // ********************************************************
  // command decoding
  // ********************************************************
  // mode, bank and blink settings
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      modeCfg <= MODE_RST;
      blinkCfg <= '0;
      inBank <= 1'b0;
      outBank <= 1'b0;
    end
    else if (cmdStrobe)
    begin
      if (shiftReg[6:5] == OP_MODE)
      begin
        modeCfg.lowPower <= shiftReg[LP_BIT];
        modeCfg.enable <= shiftReg[EN_BIT];
        modeCfg.biasHalf <= shiftReg[BIAS_BIT];
        modeCfg.drive <= lcdbs_drive_type'(shiftReg[1:0]);
      end
      else if ((shiftReg[6:2] == OP_BANK) && bankable(modeCfg.drive))
      begin
        // each bank kept apart, ignored in 3/4-way
        inBank <= shiftReg[IN_BANK_BIT];
        outBank <= shiftReg[OUT_BANK_BIT];
      end
      else if (shiftReg[6:3] == OP_BLINK)
      begin
        blinkCfg.alternate <= shiftReg[ALT_BIT];
        blinkCfg.rate <= shiftReg[1:0];
      end
    end
  end

  // ********************************************************
  // data storage engine
  // ********************************************************
  assign width = bitsPerAddr(modeCfg.drive);
  assign inBase = (bankable(modeCfg.drive) && inBank) ? BANK_BASE : 2'h0;
  assign take = (storeLeft < {1'b0, width}) ? storeLeft : {1'b0, width};

  // pointer, subaddress counter and byte scatter, one address a cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dataPtr <= '0;
      subCnt <= '0;
      storeBusy <= 1'b0;
      storeShift <= '0;
      storeLeft <= '0;
    end
    else if (dataStrobe)
    begin
      storeShift <= shiftReg;
      storeLeft <= 4'(BYTE_BITS);
      storeBusy <= 1'b1;
    end
    else if (cmdStrobe && (shiftReg[6:5] == OP_POINTER))
    begin
      dataPtr <= shiftReg[4:0];
    end
    else if (cmdStrobe && (shiftReg[6:3] == OP_DEVSEL))
    begin
      subCnt <= shiftReg[2:0];
    end
    else if (storeBusy)
    begin
      // pointer steps per address, so per byte 8/4/3/2
      if (dataPtr >= 5'(RAM_DEPTH - 1))
      begin
        dataPtr <= '0;
        subCnt <= subCnt + 1'b1;
      end
      else
      begin
        dataPtr <= dataPtr + 1'b1;
      end
      storeShift <= storeShift << take;
      storeLeft <= storeLeft - take;
      if (storeLeft <= {1'b0, width})
      begin
        storeBusy <= 1'b0;
      end
    end
  end

  // ram write word, msb of the byte into the lowest used bit
  always_comb
  begin
    ramMask = '0;
    ramData = '0;
    for (int i = 0; i < RAM_BITS; i++)
    begin
      if ((4'(i) < take) && ((i + int'(inBase)) < RAM_BITS))
      begin
        ramMask[2'(i + int'(inBase))] = 1'b1;
        ramData[2'(i + int'(inBase))] = storeShift[BYTE_BITS-1-i];
      end
    end
  end

  // write inhibited on subaddress mismatch, pointer still moves
  assign ramWe = storeBusy && (subCnt == hwSub);

  lcdbs_ram uRam (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wrEn(ramWe),
    .wrAddr(dataPtr),
    .wrMask(ramMask),
    .wrData(ramData),
    .rdBit(2'(rowIdx + outBase)),
    .rdColumn(column)
  );

  // ********************************************************
  // blinking
  // ********************************************************
  lcdbs_blinker #(
    .N2(BLINK_N2),
    .N1(BLINK_N1),
    .N05(BLINK_N05),
    .P2(BLINK_P2),
    .P1(BLINK_P1),
    .P05(BLINK_P05)
  ) uBlink (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .powerSave(modeCfg.lowPower),
    .rate(blinkCfg.rate),
    .phase(blinkPhase)
  );

  // alternation in static and two-way, plain blanking otherwise
  assign swapBank = blinkCfg.alternate && bankable(modeCfg.drive) && blinkPhase;
  assign blankNow = !(blinkCfg.alternate && bankable(modeCfg.drive)) && blinkPhase;
  assign outBase = (bankable(modeCfg.drive) && (outBank ^ swapBank)) ? BANK_BASE : 2'h0;

  // ********************************************************
  // multiplex scan and display latch
  // ********************************************************
  // last row index: static 0, two-way 1, three-way 2, four-way 3
  assign rowsLast = width - 3'h1;

  // row counter steps on each strobe and wraps per mode
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rowIdx <= '0;
    end
    else if ({1'b0, rowIdx} > rowsLast)
    begin
      rowIdx <= '0;
    end
    else if (rowAdvance)
    begin
      rowIdx <= ({1'b0, rowIdx} == rowsLast) ? 2'h0 : rowIdx + 1'b1;
    end
  end

  // latch the column for the current row, blank when disabled
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      segLatch <= '0;
      displayOn <= 1'b0;
    end
    else
    begin
      displayOn <= modeCfg.enable && !blankNow;
      segLatch <= (modeCfg.enable && !blankNow) ? column : '0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/lcdbs_pkg.sv ***
// shared constants, types and decode helpers of the display bus slave
// assumes a single 125 MHz system clock and no register bus
`default_nettype none
package lcdbs_pkg;
  // ********************************************************
  // drive modes and configuration carriers
  // ********************************************************
  typedef enum logic [1:0] {DRV_MUX4 = 2'h0, DRV_STATIC = 2'h1, DRV_MUX2 = 2'h2, DRV_MUX3 = 2'h3} lcdbs_drive_type;
  typedef struct packed {
    logic lowPower; // power-saving divisors
    logic enable; // display on
    logic biasHalf; // half bias select
    lcdbs_drive_type drive; // multiplex mode
  } lcdbs_mode_type;
  typedef struct packed {
    logic alternate; // bank alternation blinking
    logic [1:0] rate; // blink rate select
  } lcdbs_blink_type;
  // ********************************************************
  // sizes, addresses, field positions, reset values
  // ********************************************************
  localparam int RAM_DEPTH = 24;
  localparam int RAM_BITS = 4;
  localparam int BYTE_BITS = 8;
  localparam logic [5:0] ADDR_UPPER = 6'h1F; // high six address bits
  localparam logic [2:0] SYNC_RST = 3'h6; // scl, sda idle high, lsb pin low
  localparam int CONT_BIT = 7;
  localparam int LP_BIT = 4;
  localparam int EN_BIT = 3;
  localparam int BIAS_BIT = 2;
  localparam int IN_BANK_BIT = 1;
  localparam int OUT_BANK_BIT = 0;
  localparam int ALT_BIT = 2;
  localparam logic [1:0] OP_MODE = 2'h2; // bits 6:5
  localparam logic [1:0] OP_POINTER = 2'h0; // bits 6:5
  localparam logic [3:0] OP_DEVSEL = 4'hC; // bits 6:3
  localparam logic [3:0] OP_BLINK = 4'hE; // bits 6:3
  localparam logic [4:0] OP_BANK = 5'h1E; // bits 6:2
  localparam logic [1:0] BANK_BASE = 2'h2; // alternate bank bit
  localparam logic [1:0] RATE_OFF = 2'h0;
  localparam logic [1:0] RATE_2HZ = 2'h1;
  localparam logic [1:0] RATE_1HZ = 2'h2;
  localparam lcdbs_mode_type MODE_RST = '{lowPower: 1'b0, enable: 1'b0, biasHalf: 1'b0, drive: DRV_MUX4};
  // ********************************************************
  // blink divisors, clock cycles per blink period
  // ********************************************************
  localparam int DIV_N_2HZ = 92160;
  localparam int DIV_N_1HZ = 184320;
  localparam int DIV_N_05HZ = 368640;
  localparam int DIV_P_2HZ = 15360;
  localparam int DIV_P_1HZ = 30720;
  localparam int DIV_P_05HZ = 61440;
  // ********************************************************
  // decode helpers
  // ********************************************************
  function automatic logic [2:0] bitsPerAddr(input lcdbs_drive_type d);
    case (d)
      DRV_STATIC: bitsPerAddr = 3'h1;
      DRV_MUX2: bitsPerAddr = 3'h2;
      DRV_MUX3: bitsPerAddr = 3'h3;
      default: bitsPerAddr = 3'h4;
    endcase
  endfunction
  function automatic logic bankable(input lcdbs_drive_type d);
    bankable = (d == DRV_STATIC) || (d == DRV_MUX2);
  endfunction
endpackage
`default_nettype wire

// *** rtl/lcdbs_ram.sv ***
// display ram, 24 words of 4 bits, masked write, column read
// assumes writes come from the storage engine on the same clock
`default_nettype none
module lcdbs_ram
  import lcdbs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wrEn,
  input wire logic [4:0] wrAddr,
  input wire logic [RAM_BITS-1:0] wrMask,
  input wire logic [RAM_BITS-1:0] wrData,
  input wire logic [1:0] rdBit,
  output logic [RAM_DEPTH-1:0] rdColumn
);
  // ********************************************************
  // storage array
  // ********************************************************
  logic [RAM_BITS-1:0] mem [RAM_DEPTH]; // segment words

  // masked write, untouched bits keep their value
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < RAM_DEPTH; i++)
        mem[i] <= '0;
    end
    else if (wrEn && (wrAddr < 5'(RAM_DEPTH)))
    begin
      mem[wrAddr] <= (mem[wrAddr] & ~wrMask) | (wrData & wrMask);
    end
  end

  // one bit of every word forms a column
  generate
    for (genvar g = 0; g < RAM_DEPTH; g++)
    begin : gCol
      assign rdColumn[g] = mem[g][rdBit];
    end
  endgenerate
endmodule
`default_nettype wire

// *** rtl/lcdbs_blinker.sv ***
// blink phase generator, free running from the system clock
// assumes rate and power mode come from the command decoder
`default_nettype none
module lcdbs_blinker
  import lcdbs_pkg::*;
#(
  parameter int N2 = DIV_N_2HZ,
  parameter int N1 = DIV_N_1HZ,
  parameter int N05 = DIV_N_05HZ,
  parameter int P2 = DIV_P_2HZ,
  parameter int P1 = DIV_P_1HZ,
  parameter int P05 = DIV_P_05HZ,
  parameter int CNT_W = 19
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic powerSave,
  input wire logic [1:0] rate,
  output logic phase
);
  logic [CNT_W-1:0] cnt; // cycles in current half period
  logic [CNT_W-1:0] halfLast; // terminal count of half period

  // ********************************************************
  // divisor choice, follows power mode at once
  // ********************************************************
  always_comb
  begin
    case (rate)
      RATE_2HZ: halfLast = CNT_W'((powerSave ? P2 : N2) / 2 - 1);
      RATE_1HZ: halfLast = CNT_W'((powerSave ? P1 : N1) / 2 - 1);
      default: halfLast = CNT_W'((powerSave ? P05 : N05) / 2 - 1);
    endcase
  end

  // half-period counter, compare with >= so a shrink is taken at once
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt <= '0;
      phase <= 1'b0;
    end
    else if (rate == RATE_OFF)
    begin
      cnt <= '0;
      phase <= 1'b0;
    end
    else if (cnt >= halfLast)
    begin
      cnt <= '0;
      phase <= ~phase;
    end
    else
    begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** tb/lcdbs_monitor.sv ***
// port checker of the display bus slave
// assumes it is bound onto every lcdbs_bus_slave
`default_nettype none
module lcdbs_monitor
  import lcdbs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic address_lsb_select_pin,
  input wire logic hw_subaddr_bit0,
  input wire logic hw_subaddr_bit1,
  input wire logic hw_subaddr_bit2,
  input wire logic rowAdvance,
  input wire logic [RAM_DEPTH-1:0] segLatch,
  input wire logic [1:0] rowIdx,
  input wire lcdbs_mode_type modeCfg,
  input wire logic displayOn
);
  timeunit 1ns;
  timeprecision 100ps;
  // ***
  // pad, acknowledge, stretch and display timing
  // ***
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  property p_padLow;
    sclOut == 1'b0 && sdaOut == 1'b0;
  endproperty
  a_padLow: assert property (p_padLow) else $error("pad data not low");
  property p_ackRise;
    $rose(sdaOe) |-> !sclIn;
  endproperty
  a_ackRise: assert property (p_ackRise) else $error("ack began with clock high");
  property p_ackHeld;
    $fell(sdaOe) |-> !sclIn && !$past(sclIn);
  endproperty
  a_ackHeld: assert property (p_ackHeld) else $error("ack dropped in clock high");
  property p_stretchMin;
    $rose(sclOe) |-> sclOe [*2];
  endproperty
  a_stretchMin: assert property (p_stretchMin) else $error("stretch too short");
  property p_stretchEnd;
    $rose(sclOe) |-> ##[1:8] !sclOe;
  endproperty
  a_stretchEnd: assert property (p_stretchEnd) else $error("stretch too long");
  property p_rowStep;
    rowAdvance && modeCfg.drive == DRV_MUX4 |=> rowIdx == $past(rowIdx) + 2'h1;
  endproperty
  a_rowStep: assert property (p_rowStep) else $error("row did not step");
  property p_rowStatic;
    rowAdvance && modeCfg.drive == DRV_STATIC |=> rowIdx == 2'h0;
  endproperty
  a_rowStatic: assert property (p_rowStatic) else $error("static row not zero");
  property p_blankLatch;
    !modeCfg.enable [*3] |-> segLatch == '0;
  endproperty
  a_blankLatch: assert property (p_blankLatch) else $error("latch not blank");
  property p_blankFlag;
    !modeCfg.enable [*2] |-> !displayOn;
  endproperty
  a_blankFlag: assert property (p_blankFlag) else $error("display flag on");
endmodule
bind lcdbs_bus_slave lcdbs_monitor i_mon (.*);
`default_nettype wire

// *** tb/lcdbs_master_model.sv ***
// two-wire bus master model pulling open-drain lines
// assumes the bench resolves both lines with pull-ups
`default_nettype none
module lcdbs_master_model
#(
  parameter int HALF = 4
)
(
  input wire logic clk_sys,
  input wire logic sclLine,
  input wire logic sdaLine,
  output logic sclPull,
  output logic sdaPull
);
  timeunit 1ns;
  timeprecision 100ps;
  // ***
  // bus conditions and bits
  // ***
  int stretchMax = 0; // longest stretch seen
  initial
  begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // release clock, wait out a stretch
  task automatic releaseScl;
    int w;
    w = 0;
    sclPull = 1'b0;
    while (!sclLine && w < 200)
    begin
      tick(1);
      w++;
    end
    if (w > stretchMax) stretchMax = w;
  endtask
  // data falls while clock high
  task automatic startCond;
    sdaPull = 1'b0;
    tick(HALF);
    releaseScl();
    tick(HALF);
    sdaPull = 1'b1;
    tick(HALF);
    sclPull = 1'b1;
    tick(1);
  endtask
  // data rises while clock high
  task automatic stopCond;
    sdaPull = 1'b1;
    tick(HALF);
    releaseScl();
    tick(HALF);
    sdaPull = 1'b0;
    tick(HALF);
  endtask
  // data set in low phase, held through high phase
  task automatic clockBit(input logic b, output logic seen);
    sdaPull = ~b;
    tick(HALF);
    releaseScl();
    tick(HALF);
    seen = sdaLine;
    sclPull = 1'b1;
    tick(1);
  endtask
  // msb first, then the ack pulse
  task automatic sendByte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clockBit(v[i], s);
    clockBit(1'b1, s);
    ack = ~s;
  endtask
endmodule
`default_nettype wire

// *** tb/lcd_bus_slave_bank_blink_tb.sv ***
// self-checking bench of the display bus slave
// assumes the master model and the bound port checker
`default_nettype none
module lcd_bus_slave_bank_blink_tb
  import lcdbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ***
  // clock, pads, device and master
  // ***
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic address_lsb_select_pin = 1'b0;
  logic hw_subaddr_bit0 = 1'b1, hw_subaddr_bit1 = 1'b0, hw_subaddr_bit2 = 1'b1; // subaddress 5
  logic rowAdvance = 1'b0;
  logic sclPull, sdaPull, sclOut, sclOe, sdaOut, sdaOe, displayOn, sclIn, sdaIn;
  logic [RAM_DEPTH-1:0] segLatch;
  logic [1:0] rowIdx;
  lcdbs_mode_type modeCfg;
  int error_cnt = 0;
  int n_compared = 0;
  always #4 clk_sys = ~clk_sys; // 125 MHz
  assign sclIn = ~(sclPull | (sclOe & ~sclOut)); // pull-up wire
  assign sdaIn = ~(sdaPull | (sdaOe & ~sdaOut)); // pull-up wire
  lcdbs_bus_slave #(.BLINK_N2(16), .BLINK_N1(32), .BLINK_N05(64), .BLINK_P2(8), .BLINK_P1(16),
    .BLINK_P05(32)) i_dut (.*);
  lcdbs_master_model #(.HALF(4)) i_mst (.clk_sys(clk_sys), .sclLine(sclIn), .sdaLine(sdaIn),
    .sclPull(sclPull), .sdaPull(sdaPull));
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // one framed transfer, ack per byte
  task automatic xfer(input logic [7:0] b[$], output logic [15:0] acks);
    logic a;
    acks = '0;
    i_mst.startCond();
    foreach (b[i])
    begin
      i_mst.sendByte(b[i], a);
      acks[i] = a;
    end
    i_mst.stopCond();
  endtask
  task automatic rowPulse();
    rowAdvance = 1'b1;
    tick();
    rowAdvance = 1'b0;
    repeat (3) tick();
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ***
  // test sequence
  // ***
  initial
  begin
    logic [15:0] ak;
    logic [7:0] p;
    logic a;
    int n;
    logic [3:0] rowExp [4];
    int dv [2][4];
    rowExp = '{4'hD, 4'hE, 4'hE, 4'hD};
    dv = '{'{0, 16, 32, 64}, '{0, 8, 16, 32}};
    repeat (6) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (4) tick();
    check({displayOn, segLatch}, 0);
    xfer('{8'h7E, 8'h80}, ak);
    check(ak, 16'h0);
    address_lsb_select_pin = 1'b1;
    xfer('{8'h7E, 8'h70}, ak);
    check(ak, 16'h3);
    address_lsb_select_pin = 1'b0;
    $display("test address done");
    xfer('{8'h7C, 8'hC9, 8'h80, 8'hE5, 8'hF8, 8'h70, 8'hC1, 8'h0F}, ak);
    check(ak, 16'hFF);
    check(i_mst.stretchMax > 0, 1);
    check(modeCfg, 5'h09);
    rowPulse();
    check(segLatch, 24'h00F083);
    xfer('{8'h7C, 8'h90, 8'h64, 8'hFF}, ak);
    check(ak, 16'h7);
    check(segLatch, 24'h00F083);
    // hardware subaddress 6 now, data lands again
    hw_subaddr_bit0 = 1'b0;
    hw_subaddr_bit1 = 1'b1;
    xfer('{8'h7C, 8'h88, 8'h66, 8'h0E}, ak);
    check(ak, 16'hF);
    check(segLatch, 24'h007083);
    hw_subaddr_bit0 = 1'b1;
    hw_subaddr_bit1 = 1'b0;
    $display("test store done");
    xfer('{8'h7C, 8'h80, 8'hE5, 8'h7A, 8'hFF}, ak);
    check(segLatch[7:0], 8'h83);
    xfer('{8'h7C, 8'h7B}, ak);
    check(segLatch[7:0], 8'hFF);
    xfer('{8'h7C, 8'h79}, ak);
    check(segLatch[7:0], 8'hFF);
    xfer('{8'h7C, 8'h41}, ak);
    check({displayOn, segLatch}, 0);
    $display("test bank done");
    // alternation, then plain blinking, toggles counted over 64 clocks
    for (int lp = 0; lp < 2; lp++)
      for (int r = 0; r < 4; r++)
      begin
        xfer('{8'h7C, 8'hC9 | 8'(lp * 16), 8'h74 ^ 8'(lp * 4) | 8'(r)}, ak);
        repeat (70) tick();
        p = segLatch[7:0];
        n = 0;
        repeat (64)
        begin
          tick();
          n += int'(segLatch[7:0] !== p);
          p = segLatch[7:0];
        end
        check(n, r ? 128 / dv[lp][r] : 0);
      end
    $display("test blink done");
    xfer('{8'h7C, 8'hC8, 8'hF0, 8'hFB, 8'h00, 8'h96, 8'hFF}, ak);
    check(ak, 16'h7F);
    for (int r = 0; r < 4; r++)
    begin
      check(rowIdx, r);
      check(segLatch[3:0], rowExp[r]);
      rowPulse();
    end
    check(rowIdx, 0);
    // three-way: two bytes, bit 2 of the third address kept
    xfer('{8'h7C, 8'hCB, 8'h00, 8'h00, 8'h00}, ak);
    check(ak, 16'h1F);
    rowPulse();
    rowPulse();
    check(rowIdx, 2);
    check(segLatch[3:0], 4'h4);
    rowPulse();
    check(rowIdx, 0);
    $display("test multiplex done");
    i_mst.startCond();
    i_mst.sendByte(8'h7C, a);
    repeat (3) i_mst.clockBit(1'b0, a);
    xfer('{8'h7C, 8'h80}, ak);
    check(ak, 16'h3);
    $display("test abort done");
    results();
  end
  // hang guard
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
